// file: inc/pit3_pkg.sv
package pit3_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int COUNT_W = 16;
	localparam int CH_NUM = 3;
	localparam int BAUD_CH = 2;

	// ----------------------------------------
	// Channel functions
	// ----------------------------------------
	localparam logic [2:0] MODE_TCINT = 3'h0;
	localparam logic [2:0] MODE_ONESHOT = 3'h1;
	localparam logic [2:0] MODE_RATE = 3'h2;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	localparam logic [2:0] MODE_SWSTB = 3'h4;
	localparam logic [2:0] MODE_HWSTB = 3'h5;
	localparam logic [2:0] MODE_EVENT = 3'h6;

	// ----------------------------------------
	// Host command kinds
	// ----------------------------------------
	localparam logic [1:0] CMD_CFG = 2'h0;
	localparam logic [1:0] CMD_LOAD = 2'h1;
	localparam logic [1:0] CMD_LATCH = 2'h2;
	localparam logic [1:0] CMD_TRIG = 2'h3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic BCD_RST = 1'b0;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ARMED = 3'b010,
		ST_RUN = 3'b100
	} pit3_state_t;
endpackage

// file: hw/pit3_channel.sv
`timescale 1ns/1ps
module pit3_channel #(
	parameter int COUNT_W = pit3_pkg::COUNT_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] mode,
	input wire logic bcd,
	input wire logic cfgStb,
	input wire logic loadStb,
	input wire logic [COUNT_W-1:0] loadVal,
	input wire logic swTrig,
	input wire logic tick,
	input wire logic gate,
	input wire logic gateRise,
	output logic [COUNT_W-1:0] count,
	output logic [COUNT_W-1:0] reload,
	output pit3_pkg::pit3_state_t state,
	output logic step,
	output logic trigStart,
	output logic out
);
	localparam logic [COUNT_W-1:0] ONE = COUNT_W'(1);
	localparam logic [COUNT_W-1:0] TWO = COUNT_W'(2);

	if (COUNT_W < 4 || COUNT_W % 4 != 0) begin : g_bad_width
		$error("Count width must be whole decimal digits");
	end

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	function automatic logic [COUNT_W-1:0] decf(input logic [COUNT_W-1:0] v, input logic isBcd);
		logic [COUNT_W-1:0] r;
		logic borrow;
		r = v - ONE;
		borrow = 1'b1;
		if (isBcd) begin
			r = v;
			for (int d = 0; d < COUNT_W / 4; d++) begin
				if (borrow) begin
					if (v[d*4 +: 4] == 4'h0) begin
						r[d*4 +: 4] = 4'h9;
					end else begin
						r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
						borrow = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	// Digit-wise halving keeps the square-wave split right in BCD
	function automatic logic [COUNT_W-1:0] halvef(input logic [COUNT_W-1:0] v, input logic isBcd);
		logic [COUNT_W-1:0] r;
		logic carry;
		r = v >> 1;
		carry = 1'b0;
		if (isBcd) begin
			for (int d = COUNT_W / 4 - 1; d >= 0; d--) begin
				r[d*4 +: 4] = {1'b0, v[d*4+1 +: 3]} + (carry ? 4'h5 : 4'h0);
				carry = v[d*4];
			end
		end
		return r;
	endfunction

	logic trigMode;
	logic [COUNT_W-1:0] nextCount;
	logic [COUNT_W-1:0] half;

	assign trigMode = (mode == pit3_pkg::MODE_ONESHOT) || (mode == pit3_pkg::MODE_HWSTB);
	assign nextCount = decf(count, bcd); // R1
	// Gate is the counting window except in the edge-triggered functions
	assign step = tick && (state == pit3_pkg::ST_RUN) && (trigMode || gate); // R13 R11
	assign trigStart = trigMode && (state != pit3_pkg::ST_IDLE)
		&& (gateRise || (swTrig && mode == pit3_pkg::MODE_ONESHOT)); // R5 R10

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= pit3_pkg::ST_IDLE;
			count <= pit3_pkg::COUNT_RST;
			reload <= pit3_pkg::COUNT_RST;
			half <= pit3_pkg::COUNT_RST;
		end else if (cfgStb) begin
			state <= pit3_pkg::ST_IDLE;
		end else if (loadStb) begin
			reload <= loadVal; // R14
			half <= halvef(loadVal, bcd); // R7
			if (trigMode) begin
				state <= pit3_pkg::ST_ARMED;
			end else begin
				count <= loadVal;
				state <= pit3_pkg::ST_RUN;
			end
		end else if (trigStart) begin
			count <= reload; // R5 R10
			state <= pit3_pkg::ST_RUN;
		end else if (step) begin
			case (mode)
				pit3_pkg::MODE_RATE, pit3_pkg::MODE_SQUARE: begin
					count <= (count == ONE) ? reload : nextCount; // R6 R7
				end
				pit3_pkg::MODE_ONESHOT: begin
					count <= nextCount;
					if (count == ONE) begin
						state <= pit3_pkg::ST_ARMED;
					end
				end
				pit3_pkg::MODE_SWSTB, pit3_pkg::MODE_HWSTB: begin
					if (!out) begin
						state <= (mode == pit3_pkg::MODE_HWSTB) ? pit3_pkg::ST_ARMED : pit3_pkg::ST_IDLE;
					end else begin
						count <= nextCount; // R8 R9
					end
				end
				default: begin
					count <= nextCount; // R13 R11
				end
			endcase
		end
	end

	// ----------------------------------------
	// Output
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out <= 1'b1;
		end else if (cfgStb) begin
			out <= !(mode == pit3_pkg::MODE_TCINT || mode == pit3_pkg::MODE_EVENT);
		end else if (loadStb) begin
			if (mode == pit3_pkg::MODE_TCINT || mode == pit3_pkg::MODE_EVENT) begin
				out <= 1'b0;
			end
		end else if (trigStart) begin
			if (mode == pit3_pkg::MODE_ONESHOT) begin
				out <= 1'b0; // R5
			end
		end else if (step) begin
			case (mode)
				pit3_pkg::MODE_RATE: begin
					out <= (count != TWO); // R6
				end
				pit3_pkg::MODE_SQUARE: begin
					if (count == ONE) begin
						out <= 1'b1; // R7
					end else if (nextCount == half) begin
						out <= 1'b0; // R7
					end
				end
				pit3_pkg::MODE_SWSTB, pit3_pkg::MODE_HWSTB: begin
					if (!out) begin
						out <= 1'b1;
					end else if (count == ONE) begin
						out <= 1'b0; // R8 R9
					end
				end
				default: begin
					if (count == ONE) begin
						out <= 1'b1; // R4 R5 R11
					end
				end
			endcase
		end
	end
endmodule // pit3_channel

// file: hw/pit3_timer.sv
// Notes on behaviour
// [R1] Three channels, each a 16-bit count, binary or BCD by software choice.
// [R2] Each channel configured alone; seven functions chosen by host command.
// [R3] Count readable anytime; a latch command captures it without stopping.
// [R4] Terminal-count function raises its output at terminal count.
// [R5] One-shot: low on trigger edge or command, high at terminal count, retriggerable.
// [R6] Rate generator: one-clock low pulse every N input clocks.
// [R7] Square wave: high first half of count, low second half, repeat.
// [R8] Software strobe: high until load, one-clock low pulse N counts after.
// [R9] Hardware strobe: one-clock low pulse N counts after trigger rising edge.
// [R10] Hardware strobe restarts its count on another trigger rising edge.
// [R11] Event counter counts clock pin pulses in gate window; output after N.
// [R12] Third channel drives the serial baud clock; others stay general.
// [R13] Count decrements once per active input clock; terminal count ends it. Terminal-count and event functions wrap past zero and keep counting.
// [R14] Host selects function and format before loading the 16-bit count.
`timescale 1ns/1ps
module pit3_timer #(
	parameter int NCH = pit3_pkg::CH_NUM,
	parameter int COUNT_W = pit3_pkg::COUNT_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmdValid,
	input wire logic [1:0] cmdKind,
	input wire logic [1:0] cmdChan,
	input wire logic [2:0] cmdMode,
	input wire logic cmdBcd,
	input wire logic [COUNT_W-1:0] cmdData,
	input wire logic readReq,
	input wire logic [1:0] readChan,
	output logic [COUNT_W-1:0] readData,
	output logic readAck,
	output logic readLatched,
	input wire logic [NCH-1:0] chClkPin,
	input wire logic [NCH-1:0] chGatePin,
	output logic [NCH-1:0] timerOut,
	output logic [NCH-1:0] chRunning,
	output logic baudClk
);
	localparam logic [COUNT_W-1:0] ONE = COUNT_W'(1);
	localparam logic [COUNT_W-1:0] TWO = COUNT_W'(2);

	if (NCH <= pit3_pkg::BAUD_CH || NCH > 4) begin : g_bad_nch
		$error("Channel count must leave room for the baud channel and fit a 2-bit select");
	end
	if (COUNT_W != pit3_pkg::COUNT_W) begin : g_bad_cw
		$error("Count width must match the package");
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [NCH-1:0] clkS1, clkS2, clkS3, clkLvl;
	logic [NCH-1:0] gateS1, gateS2, gateS3, gateLvl;
	logic [NCH-1:0] tick, gateRise;

	// A level counts only once the last two stages agree; gate resets high so reset gives no false edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clkS1 <= '0;
			clkS2 <= '0;
			clkS3 <= '0;
			clkLvl <= '0;
			gateS1 <= '1;
			gateS2 <= '1;
			gateS3 <= '1;
			gateLvl <= '1;
		end else begin
			clkS1 <= chClkPin;
			clkS2 <= clkS1;
			clkS3 <= clkS2;
			clkLvl <= (clkS2 & clkS3) | (clkLvl & (clkS2 | clkS3));
			gateS1 <= chGatePin;
			gateS2 <= gateS1;
			gateS3 <= gateS2;
			gateLvl <= (gateS2 & gateS3) | (gateLvl & (gateS2 | gateS3));
		end
	end

	assign tick = clkS2 & clkS3 & ~clkLvl; // R13
	assign gateRise = gateS2 & gateS3 & ~gateLvl; // R9 R10

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	logic [NCH-1:0] chHit, cfgHit, loadHit, latchHit, trigHit, readHit;

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			chHit[i] = cmdValid && (cmdChan == 2'(i));
			readHit[i] = readReq && (readChan == 2'(i));
		end
	end

	// Unknown function code 7 is ignored rather than guessed at
	assign cfgHit = chHit & {NCH{cmdKind == pit3_pkg::CMD_CFG && cmdMode <= pit3_pkg::MODE_EVENT}};
	assign loadHit = chHit & {NCH{cmdKind == pit3_pkg::CMD_LOAD}};
	assign latchHit = chHit & {NCH{cmdKind == pit3_pkg::CMD_LATCH}};
	assign trigHit = chHit & {NCH{cmdKind == pit3_pkg::CMD_TRIG}};

	// ----------------------------------------
	// Channel configuration
	// ----------------------------------------
	logic [2:0] cfgMode [NCH];
	logic [NCH-1:0] cfgBcd;
	logic [NCH-1:0] cfgDone, loadStb, swTrig;
	logic [COUNT_W-1:0] loadData;

	// Strobes are delayed a cycle so the channel sees the new function with them
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NCH; i++) begin
				cfgMode[i] <= pit3_pkg::MODE_RST;
			end
			cfgBcd <= {NCH{pit3_pkg::BCD_RST}};
			cfgDone <= '0;
		end else begin
			cfgDone <= cfgHit;
			for (int i = 0; i < NCH; i++) begin
				if (cfgHit[i]) begin
					cfgMode[i] <= cmdMode; // R2
					cfgBcd[i] <= cmdBcd; // R1
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loadStb <= '0;
			swTrig <= '0;
			loadData <= pit3_pkg::COUNT_RST;
		end else begin
			loadStb <= loadHit; // R14
			swTrig <= trigHit; // R5
			if (cmdValid && cmdKind == pit3_pkg::CMD_LOAD) begin
				loadData <= cmdData;
			end
		end
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	logic [COUNT_W-1:0] chCount [NCH];
	logic [COUNT_W-1:0] chReload [NCH];
	pit3_pkg::pit3_state_t chState [NCH];
	logic [NCH-1:0] chStep, chTrigStart, chOut;

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		pit3_channel #(
			.COUNT_W(COUNT_W)
		) u_ch (
			.clk(clk),
			.rst_n(rst_n),
			.mode(cfgMode[i]),
			.bcd(cfgBcd[i]),
			.cfgStb(cfgDone[i]),
			.loadStb(loadStb[i]),
			.loadVal(loadData),
			.swTrig(swTrig[i]),
			.tick(tick[i]),
			.gate(gateLvl[i]),
			.gateRise(gateRise[i]),
			.count(chCount[i]),
			.reload(chReload[i]),
			.state(chState[i]),
			.step(chStep[i]),
			.trigStart(chTrigStart[i]),
			.out(chOut[i])
		);
	end

	// ----------------------------------------
	// Count capture and read-back
	// ----------------------------------------
	logic [COUNT_W-1:0] snap [NCH];
	logic [NCH-1:0] snapValid;

	// Repeated latches keep the first capture until it is read; a latch wins over a read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NCH; i++) begin
				snap[i] <= pit3_pkg::COUNT_RST;
			end
			snapValid <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (latchHit[i] && !snapValid[i]) begin
					snap[i] <= chCount[i]; // R3
				end
				if (latchHit[i]) begin
					snapValid[i] <= 1'b1; // R3
				end else if (readHit[i]) begin
					snapValid[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readData <= pit3_pkg::COUNT_RST;
			readAck <= 1'b0;
			readLatched <= 1'b0;
		end else begin
			readAck <= readReq; // R3
			readData <= pit3_pkg::COUNT_RST;
			readLatched <= 1'b0;
			for (int i = 0; i < NCH; i++) begin
				if (readHit[i]) begin
					readData <= snapValid[i] ? snap[i] : chCount[i]; // R3
					readLatched <= snapValid[i];
				end
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			timerOut <= '1;
			baudClk <= 1'b1;
			chRunning <= '0;
		end else begin
			timerOut <= chOut; // R4
			baudClk <= chOut[pit3_pkg::BAUD_CH]; // R12
			for (int i = 0; i < NCH; i++) begin
				chRunning[i] <= (chState[i] == pit3_pkg::ST_RUN);
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_read_ack: assert property ( // R3
		readReq |=> readAck ##1 (!readAck || $past(readReq)))
		else $error("Read not answered in one cycle");

	a_baud_follow: assert property ( // R12
		baudClk == $past(chOut[pit3_pkg::BAUD_CH]))
		else $error("Baud clock does not follow its channel");

	for (genvar i = 0; i < NCH; i++) begin : g_chk
		logic [2:0] m;
		logic quiet;
		assign m = cfgMode[i];
		assign quiet = !cfgDone[i] && !loadStb[i] && !chTrigStart[i];

		a_cfg_store: assert property ( // R2
			cfgHit[i] |=> cfgDone[i] && cfgMode[i] == $past(cmdMode))
			else $error("Function not stored");

		a_count_cause: assert property ( // R1
			$changed(chCount[i]) |-> $past(chStep[i] || loadStb[i] || chTrigStart[i]))
			else $error("Count moved without a cause");

		a_dec_binary: assert property ( // R13
			chStep[i] && quiet && !cfgBcd[i] && m == pit3_pkg::MODE_TCINT && chCount[i] != ONE
			|=> chCount[i] == $past(chCount[i]) - ONE)
			else $error("Count did not drop by one");

		a_bcd_wrap: assert property ( // R1
			chStep[i] && quiet && cfgBcd[i] && m == pit3_pkg::MODE_TCINT && chCount[i] == 16'h0000
			|=> chCount[i] == 16'h9999)
			else $error("Decimal count did not wrap to 9999");

		a_latch_snap: assert property ( // R3
			latchHit[i] && !snapValid[i] |=> snapValid[i] && snap[i] == $past(chCount[i]))
			else $error("Capture missed the live count");

		a_read_snap: assert property ( // R3
			readHit[i] && snapValid[i] && !latchHit[i]
			|=> readData == $past(snap[i]) && readLatched && !snapValid[i])
			else $error("Captured count not returned");

		a_tc_rise: assert property ( // R4
			m == pit3_pkg::MODE_TCINT && chStep[i] && quiet && chCount[i] == ONE
			|=> chOut[i] ##1 timerOut[i])
			else $error("No request at terminal count");

		a_oneshot_go: assert property ( // R5
			m == pit3_pkg::MODE_ONESHOT && chTrigStart[i] && !cfgDone[i] && !loadStb[i]
			|=> !chOut[i] && chCount[i] == $past(chReload[i]))
			else $error("One-shot did not start");

		a_oneshot_end: assert property ( // R5
			m == pit3_pkg::MODE_ONESHOT && chStep[i] && quiet && chCount[i] == ONE
			|=> chOut[i] && chState[i] == pit3_pkg::ST_ARMED)
			else $error("One-shot did not end at terminal count");

		a_rate_low: assert property ( // R6
			m == pit3_pkg::MODE_RATE && chStep[i] && quiet && chCount[i] == TWO |=> !chOut[i])
			else $error("Rate pulse missing");

		a_rate_reload: assert property ( // R6
			m == pit3_pkg::MODE_RATE && chStep[i] && quiet && chCount[i] == ONE
			|=> chOut[i] && chCount[i] == $past(chReload[i]))
			else $error("Rate period not restarted");

		a_square_half: assert property ( // R7
			m == pit3_pkg::MODE_SQUARE && !cfgBcd[i] && $fell(chOut[i]) && !$past(loadStb[i])
			|-> chCount[i] == chReload[i] >> 1)
			else $error("Square wave fell away from half count");

		a_swstb_hold: assert property ( // R8
			m == pit3_pkg::MODE_SWSTB && loadStb[i] && !cfgDone[i] |=> chOut[i])
			else $error("Strobe output low after load");

		a_swstb_pulse: assert property ( // R8
			m == pit3_pkg::MODE_SWSTB && !chOut[i] && chStep[i] && quiet
			|=> chOut[i] && chState[i] == pit3_pkg::ST_IDLE)
			else $error("Software strobe wider than one clock");

		a_hwstb_low: assert property ( // R9
			m == pit3_pkg::MODE_HWSTB && chStep[i] && quiet && chOut[i] && chCount[i] == ONE
			|=> !chOut[i])
			else $error("Hardware strobe missing");

		a_hwstb_retrig: assert property ( // R10
			m == pit3_pkg::MODE_HWSTB && chTrigStart[i] && !cfgDone[i] && !loadStb[i]
			|=> chCount[i] == $past(chReload[i]) && chState[i] == pit3_pkg::ST_RUN)
			else $error("Trigger did not restart the strobe");

		a_event_window: assert property ( // R11
			m == pit3_pkg::MODE_EVENT && !gateLvl[i] && quiet |=> $stable(chCount[i]))
			else $error("Events counted outside the window");

		c_rate_pulse: cover property (m == pit3_pkg::MODE_RATE && $fell(chOut[i]));
		c_square_fall: cover property (m == pit3_pkg::MODE_SQUARE && $fell(chOut[i]));
		c_hw_retrig: cover property (m == pit3_pkg::MODE_HWSTB && chTrigStart[i]
			&& chState[i] == pit3_pkg::ST_RUN);
	end

	c_read_latched: cover property (readAck && readLatched);
endmodule // pit3_timer

// file: tb/pit3_pin_source.sv
`timescale 1ns/1ps
module pit3_pin_source (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [1:0] sel,
	output logic [2:0] pins,
	output logic busy
);
	// ----------------------------------------
	// One input-clock pulse per request
	// ----------------------------------------
	// High 3 cycles, low 4: slow enough for the pin synchroniser
	logic [2:0] phase;
	logic [1:0] chan;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase <= 3'h0;
		end else if (phase != 3'h0 || go) begin
			phase <= phase + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (go && phase == 3'h0) begin
			chan <= sel;
		end
	end

	// Pin rests low between pulses
	assign pins = (phase >= 3'h1 && phase <= 3'h3) ? 3'h1 << chan : 3'h0;
	assign busy = phase != 3'h0;
endmodule // pit3_pin_source

// file: tb/pit3_timer_test.sv
`timescale 1ns/1ps
module pit3_timer_test;
	logic clk, rst_n, readAck, readLatched, baudClk, busy, rl;
	logic cmdValid = 1'h0, cmdBcd = 1'h0, readReq = 1'h0, go = 1'h0;
	logic [1:0] cmdKind = 2'h0, cmdChan = 2'h0, readChan = 2'h0, sel = 2'h0;
	logic [2:0] cmdMode = 3'h0, chGatePin = 3'h7;
	logic [2:0] chClkPin, timerOut, chRunning;
	logic [15:0] cmdData = 16'h0000;
	logic [15:0] readData, rv;
	logic [31:0] seed = 32'h00aa;
	int error_cnt, checked, cyc, n, j, t;

	pit3_timer pit3_timer_i (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdKind(cmdKind),
		.cmdChan(cmdChan), .cmdMode(cmdMode), .cmdBcd(cmdBcd), .cmdData(cmdData), .readReq(readReq),
		.readChan(readChan), .readData(readData), .readAck(readAck), .readLatched(readLatched),
		.chClkPin(chClkPin), .chGatePin(chGatePin), .timerOut(timerOut), .chRunning(chRunning),
		.baudClk(baudClk));
	pit3_pin_source pit3_pin_source_i (.clk(clk), .rst_n(rst_n), .go(go), .sel(sel), .pins(chClkPin),
		.busy(busy));

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic waitCyc(int k);
		repeat (k) @(posedge clk);
		#2;
	endtask

	task automatic cmd(logic [1:0] k, logic [1:0] c, logic [2:0] m, logic b, logic [15:0] d);
		cmdValid = 1'h1;
		cmdKind = k;
		cmdChan = c;
		cmdMode = m;
		cmdBcd = b;
		cmdData = d;
		waitCyc(1);
		cmdValid = 1'h0;
		waitCyc(3);
	endtask

	task automatic rd(logic [1:0] c);
		readReq = 1'h1;
		readChan = c;
		waitCyc(1);
		readReq = 1'h0;
		rv = readData;
		rl = readLatched;
		check(readAck, 1'h1);
		waitCyc(1);
		check(readAck, 1'h0);
	endtask

	task automatic tick(int c);
		go = 1'h1;
		sel = 2'(c);
		waitCyc(1);
		go = 1'h0;
		while (busy) waitCyc(1);
		waitCyc(2);
	endtask

	// Gate low long enough to pass the synchroniser, then a rising edge
	task automatic gatePulse(int c);
		chGatePin[c] = 1'h0;
		waitCyc(4);
		chGatePin[c] = 1'h1;
		waitCyc(6);
	endtask

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Output level after j input clocks from load or trigger
	function automatic logic expOut(int m, int nn, int jj);
		case (m)
			0, 1, 6: return jj == nn;
			2: return jj != nn - 1;
			3: return (nn - jj) > nn / 2;
			default: return jj != nn;
		endcase
	endfunction

	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			results();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'h0;
		waitCyc(3);
		check(timerOut, 3'h7);
		check(baudClk, 1'h1);
		rst_n = 1'h1;
		for (int m = 0; m < 7; m++) begin
			t = m % 3;
			n = 3 + int'(rnd() % 32'h6);
			cmd(pit3_pkg::CMD_CFG, 2'(t), 3'(m), 1'h0, 16'h0000);
			cmd(pit3_pkg::CMD_LOAD, 2'(t), 3'h0, 1'h0, 16'(n));
			if (m == 1 || m == 5) begin
				check(chRunning[t], 1'h0);
				// Third trigger lands mid-count and must restart it
				for (int r = 0; r < 3; r++) begin
					if (m == 1) cmd(pit3_pkg::CMD_TRIG, 2'(t), 3'h0, 1'h0, 16'h0000);
					else gatePulse(t);
					if (r < 2) tick(t);
				end
			end
			if (m == 2) check(chRunning[t], 1'h1);
			for (j = 0; j <= n - int'(m == 3); j++) begin
				if (j > 0) tick(t);
				check(timerOut[t], expOut(m, n, j));
				rd(2'(t));
				check(rv, 16'((m == 2 && j == n) ? n : n - j));
				check(baudClk, timerOut[2]);
			end
		end
		// Event window closed: pulses ignored
		cmd(pit3_pkg::CMD_LOAD, 2'h0, 3'h0, 1'h0, 16'h0005);
		chGatePin[0] = 1'h0;
		waitCyc(4);
		tick(0);
		tick(0);
		rd(2'h0);
		check(rv, 16'h0005);
		chGatePin[0] = 1'h1;
		waitCyc(4);
		tick(0);
		rd(2'h0);
		check(16'h0005 - rv, 16'h0001);
		// Decimal counting across digit borrows
		cmd(pit3_pkg::CMD_CFG, 2'h1, pit3_pkg::MODE_TCINT, 1'h1, 16'h0000);
		cmd(pit3_pkg::CMD_LOAD, 2'h1, 3'h0, 1'h0, 16'h0010);
		tick(1);
		rd(2'h1);
		check(rv, 16'h0009);
		cmd(pit3_pkg::CMD_LOAD, 2'h1, 3'h0, 1'h0, 16'h0000);
		tick(1);
		rd(2'h1);
		check(rv, 16'h9999);
		// Capture holds while the counter keeps running
		cmd(pit3_pkg::CMD_LATCH, 2'h1, 3'h0, 1'h0, 16'h0000);
		tick(1);
		rd(2'h1);
		check(rv, 16'h9999);
		check(rl, 1'h1);
		rd(2'h1);
		check(rv, 16'h9998);
		check(rl, 1'h0);
		rd(2'h3);
		check(rv, 16'h0000);
		// Function code 7 is refused: channel keeps counting in decimal
		cmd(pit3_pkg::CMD_CFG, 2'h1, 3'h7, 1'h0, 16'h0000);
		tick(1);
		rd(2'h1);
		check(rv, 16'h9997);
		results();
	end
endmodule // pit3_timer_test
